// File: hw/atr_pkg.sv
// Summary of operation
// - Remote relay commands accepted only in manual mode
// - Manual mode blocks alarm relay drive, still logs
// - Remote open/close logs distinct comm event
// - Alarms evaluate and log regardless of breaker
// - Relay follows enabled alarms regardless of breaker
// - Relay control refused unless alarm enabled
// - Modes: off, log only, log+relay+alarm log
// - Alarm log holds last relay-closing function or remote command
// - Over-range active after delay above threshold
// - Over-range release after one second all below
// - Negative threshold: negative, larger magnitude exceeds
// - Phase 1-40000 A, delays 1-255 s
// - Ground current threshold 1-4000 A
// - Under-range active after delay below threshold
// - Under-range release after one second all above
// - Under-voltage threshold 60-660 V
// - Unbalance percent versus mean of three
// - Mean always includes all three values
// - Only values above 15% rating used
// - Unbalance active after delay, one-second release
// - Relay opens when all relay functions clear
// - Log activation with data, deactivation plain
package atr_pkg;
  localparam int NFUNC = 5;
  localparam int MW    = 24;

  localparam int F_OVER_PH  = 0;
  localparam int F_OVER_GND = 1;
  localparam int F_UNDER_V  = 2;
  localparam int F_UNB_I    = 3;
  localparam int F_UNB_V    = 4;

  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_RCMD      = 8'h04;
  localparam logic [7:0] REG_STATUS    = 8'h08;
  localparam logic [7:0] REG_ALOG      = 8'h0c;
  localparam logic [7:0] REG_PRATE     = 8'h10;
  localparam logic [7:0] REG_VSCALE    = 8'h14;
  localparam logic [3:0] FUNC_BASE_HI  = 4'h4;
  localparam logic [1:0] FOFS_MODE     = 2'h0;
  localparam logic [1:0] FOFS_THR      = 2'h1;
  localparam logic [1:0] FOFS_DLY      = 2'h2;

  localparam int CTRL_MANUAL_BIT = 0;
  localparam int RCMD_CLOSE_BIT  = 0;
  localparam int RCMD_OPEN_BIT   = 1;
  localparam int MODE_ALARM_BIT  = 0;
  localparam int MODE_RELAY_BIT  = 1;
  localparam int ST_RELAY_BIT    = 0;
  localparam int ST_MANUAL_BIT   = 1;
  localparam int ST_BREAKER_BIT  = 2;
  localparam int ST_ACTIVE_LSB   = 8;

  localparam int SEC_NS  = 1000000000;
  localparam int CLK_NS  = 100;
  localparam int SEC_CYC = SEC_NS / CLK_NS;

  localparam int UNB_USE_PCT = 15;
  localparam int PCT_SCALE   = 100;

  localparam logic signed [MW-1:0] THR_MIN [NFUNC] = '{24'sh1, 24'sh1, 24'sh3c, 24'sh5, 24'sh5};
  localparam logic signed [MW-1:0] THR_MAX [NFUNC] = '{24'sh9c40, 24'shfa0, 24'sh294, 24'sh32, 24'sh32};
  localparam logic [7:0] DLY_MIN = 8'h01;
  localparam logic [7:0] DLY_MAX = 8'hff;
  localparam logic [MW-1:0] PRATE_RST  = 24'h0003e8;
  localparam logic [MW-1:0] VSCALE_RST = 24'h000258;

  localparam logic [3:0] ALOG_NONE       = 4'hd;
  localparam logic [3:0] ALOG_COMM_CLOSE = 4'he;
  localparam logic [3:0] ALOG_COMM_OPEN  = 4'hf;

  typedef enum logic [2:0] {
    EV_NONE       = 3'b000,
    EV_ACT        = 3'b001,
    EV_DEACT      = 3'b010,
    EV_RLY_CLOSE  = 3'b011,
    EV_RLY_OPEN   = 3'b100,
    EV_COMM_CLOSE = 3'b101,
    EV_COMM_OPEN  = 3'b110
  } atr_evt_t;

  typedef enum logic {
    ST_IDLE   = 1'b0,
    ST_ACTIVE = 1'b1
  } atr_alm_st_t;
endpackage

// File: hw/atr_top.sv
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module atr_top #(
  parameter int SEC_CYCLES = atr_pkg::SEC_CYC
) (
  input  wire logic                           MCLK,
  input  wire logic                           RST,
  input  wire logic [7:0]                     AVS_ADDRESS,
  input  wire logic                           AVS_READ,
  input  wire logic                           AVS_WRITE,
  input  wire logic [31:0]                    AVS_WRITEDATA,
  output logic      [31:0]                    AVS_READDATA,
  output logic                                AVS_WAITREQUEST,
  input  wire logic signed [atr_pkg::MW-1:0]  MEAS_IA,
  input  wire logic signed [atr_pkg::MW-1:0]  MEAS_IB,
  input  wire logic signed [atr_pkg::MW-1:0]  MEAS_IC,
  input  wire logic signed [atr_pkg::MW-1:0]  MEAS_GROUND_CURRENT,
  input  wire logic signed [atr_pkg::MW-1:0]  MEAS_VAB,
  input  wire logic signed [atr_pkg::MW-1:0]  MEAS_VBC,
  input  wire logic signed [atr_pkg::MW-1:0]  MEAS_VCA,
  input  wire logic                           BREAKER_CLOSED,
  output logic                                RELAY_CLOSE,
  output logic                                EVT_VALID,
  output atr_pkg::atr_evt_t                   EVT_KIND,
  output logic      [3:0]                     EVT_FUNC,
  output logic      [atr_pkg::MW-1:0]         EVT_DATA
);
  import atr_pkg::*;

  localparam logic [23:0] SEC_LAST = 24'(SEC_CYCLES - 1);

  logic [23:0]              sec_cnt_reg;
  logic                     tick;
  logic                     ack_reg;
  logic [31:0]              rdata_reg;
  logic                     wr_fire;
  logic                     fn_hit;
  logic [2:0]               fsel;
  logic                     manual_reg;
  logic                     relay_reg;
  logic [3:0]               alog_reg;
  logic [MW-1:0]            prate_reg;
  logic [MW-1:0]            vscale_reg;
  logic [1:0]               mode_reg [NFUNC];
  logic signed [MW-1:0]     thr_reg [NFUNC];
  logic [7:0]               dly_reg [NFUNC];
  atr_alm_st_t              st_reg [NFUNC];
  logic [7:0]               dcnt_reg [NFUNC];
  logic [23:0]              rcnt_reg [NFUNC];
  logic [MW-1:0]            hit_reg [NFUNC];
  logic [NFUNC-1:0]         cond;
  logic [NFUNC-1:0]         relc;
  logic [MW-1:0]            hit [NFUNC];
  logic [NFUNC-1:0]         act_set;
  logic [NFUNC-1:0]         deact_set;
  logic [NFUNC-1:0]         active;
  logic [NFUNC-1:0]         relay_fn;
  logic [NFUNC-1:0]         pend_act_reg;
  logic [NFUNC-1:0]         pend_deact_reg;
  logic [NFUNC-1:0]         clr_act;
  logic [NFUNC-1:0]         clr_deact;
  logic                     cmd_close;
  logic                     cmd_open;
  logic                     auto_req;
  logic                     auto_close;
  logic                     auto_open;
  logic [3:0]               close_id;
  logic [3:0]               last_rel_id_reg;
  logic [3:0]               rclose_id_reg;
  logic [3:0]               ropen_id_reg;
  logic                     pend_rclose_reg;
  logic                     pend_ropen_reg;
  logic                     pend_cclose_reg;
  logic                     pend_copen_reg;
  logic                     clr_rclose;
  logic                     clr_ropen;
  logic                     clr_cclose;
  logic                     clr_copen;
  logic                     evt_valid_next;
  atr_evt_t                 evt_kind_next;
  logic [3:0]               evt_func_next;
  logic [MW-1:0]            evt_data_next;
  atr_evt_t                 evt_kind_reg;
  logic                     evt_valid_reg;
  logic [3:0]               evt_func_reg;
  logic [MW-1:0]            evt_data_reg;

  // Signed over-range test; a negative threshold needs a more negative value
  function automatic logic ovr_ex(input logic signed [MW-1:0] m, input logic signed [MW-1:0] t);
    return t[MW-1] ? (m < t) : (m > t);
  endfunction

  function automatic logic ovr_bl(input logic signed [MW-1:0] m, input logic signed [MW-1:0] t);
    return t[MW-1] ? (m > t) : (m < t);
  endfunction

  function automatic logic [MW-1:0] mag(input logic signed [MW-1:0] v);
    return v[MW-1] ? MW'(-v) : v;
  endfunction

  // Returns {exceeds, all below}; compares 3*|x-mean| * 100 against thr * sum
  function automatic logic [1:0] unb(input logic [MW-1:0] a, input logic [MW-1:0] b,
                                     input logic [MW-1:0] c, input logic [7:0] thr,
                                     input logic [MW-1:0] rate);
    logic [25:0] sum;
    logic [25:0] x3;
    logic [39:0] lim;
    logic [39:0] dev;
    logic [MW-1:0] x;
    logic ex;
    logic bl;
    sum = 26'(a) + 26'(b) + 26'(c);
    lim = 40'(thr) * 40'(sum);
    ex = 1'b0;
    bl = 1'b1;
    for (int i = 0; i < 3; i++) begin
      x = (i == 0) ? a : ((i == 1) ? b : c);
      x3 = 26'(x) * 26'h3;
      dev = 40'((x3 > sum) ? (x3 - sum) : (sum - x3)) * 40'(PCT_SCALE);
      if (40'(x) * 40'(PCT_SCALE) > 40'(rate) * 40'(UNB_USE_PCT)) begin
        if (dev > lim) begin
          ex = 1'b1;
        end
        if (!(dev < lim)) begin
          bl = 1'b0;
        end
      end
    end
    return {ex, bl};
  endfunction

  // One-second time base for delay counting
  assign tick = (sec_cnt_reg == SEC_LAST);
  always_ff @(posedge MCLK) begin
    if (RST || tick) begin
      sec_cnt_reg <= 24'h000000;
    end else begin
      sec_cnt_reg <= sec_cnt_reg + 24'h000001;
    end
  end

  // Avalon slave: one wait cycle, then the access completes
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_reg;
  assign wr_fire = AVS_WRITE && ack_reg;
  assign fn_hit = (AVS_ADDRESS[7:4] >= FUNC_BASE_HI) && (AVS_ADDRESS[7:4] < FUNC_BASE_HI + 4'(NFUNC));
  assign fsel = 3'(AVS_ADDRESS[7:4] - FUNC_BASE_HI);
  assign AVS_READDATA = rdata_reg;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (AVS_READ || AVS_WRITE) && !ack_reg;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      rdata_reg <= 32'h00000000;
    end else if (AVS_READ && !ack_reg) begin
      rdata_reg <= 32'h00000000;
      if (fn_hit) begin
        case (AVS_ADDRESS[3:2])
          FOFS_MODE: rdata_reg <= 32'(mode_reg[fsel]);
          FOFS_THR:  rdata_reg <= 32'(thr_reg[fsel]);
          FOFS_DLY:  rdata_reg <= 32'(dly_reg[fsel]);
          default:   rdata_reg <= 32'h00000000;
        endcase
      end else begin
        case (AVS_ADDRESS)
          REG_CTRL:   rdata_reg <= 32'(manual_reg);
          REG_STATUS: rdata_reg <= (32'(active) << ST_ACTIVE_LSB) | (32'(BREAKER_CLOSED) << ST_BREAKER_BIT)
                                   | (32'(manual_reg) << ST_MANUAL_BIT) | (32'(relay_reg) << ST_RELAY_BIT);
          REG_ALOG:   rdata_reg <= 32'(alog_reg);
          REG_PRATE:  rdata_reg <= 32'(prate_reg);
          REG_VSCALE: rdata_reg <= 32'(vscale_reg);
          default:    rdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  // Global configuration
  always_ff @(posedge MCLK) begin
    if (RST) begin
      manual_reg <= 1'b0;
      prate_reg  <= PRATE_RST;
      vscale_reg <= VSCALE_RST;
    end else if (wr_fire && !fn_hit) begin
      case (AVS_ADDRESS)
        REG_CTRL:   manual_reg <= AVS_WRITEDATA[CTRL_MANUAL_BIT];
        REG_PRATE:  prate_reg  <= AVS_WRITEDATA[MW-1:0];
        REG_VSCALE: vscale_reg <= AVS_WRITEDATA[MW-1:0];
        default:    manual_reg <= manual_reg;
      endcase
    end
  end

  // Per-function settings; out-of-range values are refused
  always_ff @(posedge MCLK) begin
    if (RST) begin
      for (int f = 0; f < NFUNC; f++) begin
        mode_reg[f] <= 2'b00;
        thr_reg[f]  <= THR_MIN[f];
        dly_reg[f]  <= DLY_MIN;
      end
    end else if (wr_fire && fn_hit) begin
      case (AVS_ADDRESS[3:2])
        FOFS_MODE: begin
          mode_reg[fsel][MODE_ALARM_BIT] <= AVS_WRITEDATA[MODE_ALARM_BIT];
          mode_reg[fsel][MODE_RELAY_BIT] <= AVS_WRITEDATA[MODE_RELAY_BIT] && AVS_WRITEDATA[MODE_ALARM_BIT];
        end
        FOFS_THR: begin
          if ($signed(AVS_WRITEDATA[MW-1:0]) >= THR_MIN[fsel]
              && $signed(AVS_WRITEDATA[MW-1:0]) <= THR_MAX[fsel]) begin
            thr_reg[fsel] <= $signed(AVS_WRITEDATA[MW-1:0]);
          end
        end
        FOFS_DLY: begin
          if (AVS_WRITEDATA[31:8] == 24'h000000 && AVS_WRITEDATA[7:0] >= DLY_MIN) begin
            dly_reg[fsel] <= AVS_WRITEDATA[7:0];
          end
        end
        default: begin
          dly_reg[fsel] <= dly_reg[fsel];
        end
      endcase
    end
  end

  // Pickup and release conditions; breaker position is not consulted
  always_comb begin
    logic [1:0] ui;
    logic [1:0] uv;
    ui = unb(mag(MEAS_IA), mag(MEAS_IB), mag(MEAS_IC), thr_reg[F_UNB_I][7:0], prate_reg);
    uv = unb(mag(MEAS_VAB), mag(MEAS_VBC), mag(MEAS_VCA), thr_reg[F_UNB_V][7:0], vscale_reg);
    cond[F_OVER_PH] = ovr_ex(MEAS_IA, thr_reg[F_OVER_PH]) || ovr_ex(MEAS_IB, thr_reg[F_OVER_PH])
                      || ovr_ex(MEAS_IC, thr_reg[F_OVER_PH]);
    relc[F_OVER_PH] = ovr_bl(MEAS_IA, thr_reg[F_OVER_PH]) && ovr_bl(MEAS_IB, thr_reg[F_OVER_PH])
                      && ovr_bl(MEAS_IC, thr_reg[F_OVER_PH]);
    hit[F_OVER_PH] = ovr_ex(MEAS_IA, thr_reg[F_OVER_PH]) ? MEAS_IA
                     : (ovr_ex(MEAS_IB, thr_reg[F_OVER_PH]) ? MEAS_IB : MEAS_IC);
    cond[F_OVER_GND] = ovr_ex(MEAS_GROUND_CURRENT, thr_reg[F_OVER_GND]);
    relc[F_OVER_GND] = ovr_bl(MEAS_GROUND_CURRENT, thr_reg[F_OVER_GND]);
    hit[F_OVER_GND] = MEAS_GROUND_CURRENT;
    cond[F_UNDER_V] = (MEAS_VAB < thr_reg[F_UNDER_V]) || (MEAS_VBC < thr_reg[F_UNDER_V])
                      || (MEAS_VCA < thr_reg[F_UNDER_V]);
    relc[F_UNDER_V] = (MEAS_VAB > thr_reg[F_UNDER_V]) && (MEAS_VBC > thr_reg[F_UNDER_V])
                      && (MEAS_VCA > thr_reg[F_UNDER_V]);
    hit[F_UNDER_V] = (MEAS_VAB < thr_reg[F_UNDER_V]) ? MEAS_VAB
                     : ((MEAS_VBC < thr_reg[F_UNDER_V]) ? MEAS_VBC : MEAS_VCA);
    cond[F_UNB_I] = ui[1];
    relc[F_UNB_I] = ui[0];
    hit[F_UNB_I] = mag(MEAS_IA);
    cond[F_UNB_V] = uv[1];
    relc[F_UNB_V] = uv[0];
    hit[F_UNB_V] = mag(MEAS_VAB);
  end

  // Pickup delay and release timing per function
  for (genvar f = 0; f < NFUNC; f++) begin : g_fn
    assign active[f]    = (st_reg[f] == ST_ACTIVE);
    assign relay_fn[f]  = mode_reg[f][MODE_RELAY_BIT];
    assign act_set[f]   = mode_reg[f][MODE_ALARM_BIT] && (st_reg[f] == ST_IDLE) && cond[f] && tick
                          && (dcnt_reg[f] >= dly_reg[f]);
    assign deact_set[f] = mode_reg[f][MODE_ALARM_BIT] && active[f] && relc[f]
                          && (rcnt_reg[f] == SEC_LAST);

    always_ff @(posedge MCLK) begin
      if (RST || !mode_reg[f][MODE_ALARM_BIT]) begin
        st_reg[f]   <= ST_IDLE;
        dcnt_reg[f] <= 8'h00;
        rcnt_reg[f] <= 24'h000000;
      end else begin
        case (st_reg[f])
          ST_IDLE: begin
            rcnt_reg[f] <= 24'h000000;
            if (!cond[f]) begin
              dcnt_reg[f] <= 8'h00;
            end else if (act_set[f]) begin
              st_reg[f]   <= ST_ACTIVE;
              dcnt_reg[f] <= 8'h00;
            end else if (tick) begin
              dcnt_reg[f] <= dcnt_reg[f] + 8'h01;
            end
          end
          ST_ACTIVE: begin
            if (!relc[f]) begin
              rcnt_reg[f] <= 24'h000000;
            end else if (deact_set[f]) begin
              st_reg[f]   <= ST_IDLE;
              rcnt_reg[f] <= 24'h000000;
            end else begin
              rcnt_reg[f] <= rcnt_reg[f] + 24'h000001;
            end
          end
          default: st_reg[f] <= ST_IDLE;
        endcase
      end
    end

    always_ff @(posedge MCLK) begin
      if (RST) begin
        hit_reg[f] <= '0;
      end else if (act_set[f]) begin
        hit_reg[f] <= hit[f];
      end
    end
  end

  // Relay output control
  assign cmd_close  = wr_fire && !fn_hit && (AVS_ADDRESS == REG_RCMD) && manual_reg
                      && AVS_WRITEDATA[RCMD_CLOSE_BIT];
  assign cmd_open   = wr_fire && !fn_hit && (AVS_ADDRESS == REG_RCMD) && manual_reg
                      && AVS_WRITEDATA[RCMD_OPEN_BIT] && !AVS_WRITEDATA[RCMD_CLOSE_BIT];
  assign auto_req   = |(active & relay_fn);
  assign auto_close = !manual_reg && auto_req && !relay_reg;
  assign auto_open  = !manual_reg && !auto_req && relay_reg;

  always_comb begin
    close_id = ALOG_NONE;
    for (int f = NFUNC - 1; f >= 0; f--) begin
      if (active[f] && relay_fn[f]) begin
        close_id = 4'(f);
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      relay_reg <= 1'b0;
    end else if (manual_reg) begin
      if (cmd_close) begin
        relay_reg <= 1'b1;
      end else if (cmd_open) begin
        relay_reg <= 1'b0;
      end
    end else begin
      relay_reg <= auto_req;
    end
  end
  assign RELAY_CLOSE = relay_reg;

  // Alarm log: cause of last automatic relay close or remote command
  always_ff @(posedge MCLK) begin
    if (RST) begin
      alog_reg <= ALOG_NONE;
    end else if (cmd_close) begin
      alog_reg <= ALOG_COMM_CLOSE;
    end else if (cmd_open) begin
      alog_reg <= ALOG_COMM_OPEN;
    end else if (auto_close) begin
      alog_reg <= close_id;
    end
  end

  // Function that last released while holding the relay
  always_ff @(posedge MCLK) begin
    if (RST) begin
      last_rel_id_reg <= ALOG_NONE;
    end else begin
      for (int f = NFUNC - 1; f >= 0; f--) begin
        if (deact_set[f] && relay_fn[f]) begin
          last_rel_id_reg <= 4'(f);
        end
      end
    end
  end

  // Pending events; a new set wins over the grant that clears it
  always_ff @(posedge MCLK) begin
    if (RST) begin
      pend_act_reg    <= '0;
      pend_deact_reg  <= '0;
      pend_rclose_reg <= 1'b0;
      pend_ropen_reg  <= 1'b0;
      pend_cclose_reg <= 1'b0;
      pend_copen_reg  <= 1'b0;
      rclose_id_reg   <= ALOG_NONE;
      ropen_id_reg    <= ALOG_NONE;
    end else begin
      pend_act_reg    <= (pend_act_reg & ~clr_act) | act_set;
      pend_deact_reg  <= (pend_deact_reg & ~clr_deact) | deact_set;
      pend_rclose_reg <= (pend_rclose_reg && !clr_rclose) || auto_close;
      pend_ropen_reg  <= (pend_ropen_reg && !clr_ropen) || auto_open;
      pend_cclose_reg <= (pend_cclose_reg && !clr_cclose) || cmd_close;
      pend_copen_reg  <= (pend_copen_reg && !clr_copen) || cmd_open;
      if (auto_close) begin
        rclose_id_reg <= close_id;
      end
      if (auto_open) begin
        ropen_id_reg <= last_rel_id_reg;
      end
    end
  end

  // One event per cycle: remote, activations, releases, relay
  always_comb begin
    clr_act        = '0;
    clr_deact      = '0;
    clr_rclose     = 1'b0;
    clr_ropen      = 1'b0;
    clr_cclose     = 1'b0;
    clr_copen      = 1'b0;
    evt_valid_next = 1'b1;
    evt_kind_next  = EV_NONE;
    evt_func_next  = ALOG_NONE;
    evt_data_next  = '0;
    if (pend_cclose_reg) begin
      clr_cclose    = 1'b1;
      evt_kind_next = EV_COMM_CLOSE;
      evt_func_next = ALOG_COMM_CLOSE;
    end else if (pend_copen_reg) begin
      clr_copen     = 1'b1;
      evt_kind_next = EV_COMM_OPEN;
      evt_func_next = ALOG_COMM_OPEN;
    end else if (|pend_act_reg) begin
      for (int f = NFUNC - 1; f >= 0; f--) begin
        if (pend_act_reg[f]) begin
          evt_func_next = 4'(f);
          evt_data_next = hit_reg[f];
        end
      end
      clr_act[3'(evt_func_next)] = 1'b1;
      evt_kind_next = EV_ACT;
    end else if (|pend_deact_reg) begin
      for (int f = NFUNC - 1; f >= 0; f--) begin
        if (pend_deact_reg[f]) begin
          evt_func_next = 4'(f);
        end
      end
      clr_deact[3'(evt_func_next)] = 1'b1;
      evt_kind_next = EV_DEACT;
    end else if (pend_rclose_reg) begin
      clr_rclose    = 1'b1;
      evt_kind_next = EV_RLY_CLOSE;
      evt_func_next = rclose_id_reg;
    end else if (pend_ropen_reg) begin
      clr_ropen     = 1'b1;
      evt_kind_next = EV_RLY_OPEN;
      evt_func_next = ropen_id_reg;
    end else begin
      evt_valid_next = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      evt_valid_reg <= 1'b0;
      evt_kind_reg  <= EV_NONE;
      evt_func_reg  <= ALOG_NONE;
      evt_data_reg  <= '0;
    end else begin
      evt_valid_reg <= evt_valid_next;
      evt_kind_reg  <= evt_kind_next;
      evt_func_reg  <= evt_func_next;
      evt_data_reg  <= evt_data_next;
    end
  end
  assign EVT_VALID = evt_valid_reg;
  assign EVT_KIND  = evt_kind_reg;
  assign EVT_FUNC  = evt_func_reg;
  assign EVT_DATA  = evt_data_reg;
endmodule

// File: test/alarm_threshold_relay_control_tb.sv
`timescale 1ns/1ps
module alarm_threshold_relay_control_tb;
  import atr_pkg::*;
  localparam int SC = 20;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} atr_row_t;
  logic                 mclk = 1'b0;
  logic                 rst = 1'b1;
  logic                 brk = 1'b0;
  logic signed [MW-1:0] ic = 24'sh1f4;
  logic signed [MW-1:0] vbc = 24'sh190;
  logic [7:0]           addr;
  logic                 rd, wr, wreq, rly, ev;
  logic [31:0]          wdata, rdata, q;
  atr_evt_t             kind;
  logic [3:0]           func;
  logic [MW-1:0]        data;
  int                   n_fail = 0;
  int                   n_compared = 0;
  int                   n;
  atr_row_t rows [9] = '{'{8'h44, 32'h9c40, 32'h9c40}, '{8'h44, 32'h9c41, 32'h9c40}, '{8'h54, 32'hfa1, 32'h1},
    '{8'h64, 32'h3b, 32'h3c}, '{8'h64, 32'h294, 32'h294}, '{8'h48, 32'h0, 32'h1}, '{8'h48, 32'hff, 32'hff},
    '{8'h40, 32'h2, 32'h0}, '{8'h30, 32'h5, 32'h0}};
  always #50 mclk = ~mclk;
  atr_top #(.SEC_CYCLES(SC)) u_dut (.MCLK(mclk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .MEAS_IA(24'sh1f4), .MEAS_IB(24'sh1f4),
    .MEAS_IC(ic), .MEAS_GROUND_CURRENT(24'sh1f4), .MEAS_VAB(24'sh190), .MEAS_VBC(vbc), .MEAS_VCA(24'sh190),
    .BREAKER_CLOSED(brk), .RELAY_CLOSE(rly), .EVT_VALID(ev), .EVT_KIND(kind), .EVT_FUNC(func), .EVT_DATA(data));
  atr_mst u_mst (.clk(mclk), .wait_req(wreq), .rdata(rdata), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata));
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wreg(logic [7:0] a, logic [31:0] d);
    u_mst.acc(1'b1, a, d, q);
  endtask
  task automatic rreg(string nm, logic [7:0] a, logic [31:0] e);
    u_mst.acc(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  task automatic wevt(atr_evt_t k, logic [3:0] f);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (ev !== 1'b1 && n < 200);
    chk("event kind", kind, k);
    chk("event function", func, f);
  endtask
  task automatic end_sim;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    end_sim;
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk("relay at reset", rly, 32'h0);
    rreg("alarm log at reset", REG_ALOG, ALOG_NONE);
    foreach (rows[i]) begin
      wreg(rows[i].a, rows[i].d);
      rreg("register", rows[i].a, rows[i].e);
    end
    $display("test registers done");
    wreg(8'h44, 32'h3e8);
    wreg(8'h48, 32'h2);
    wreg(8'h40, 32'h3);
    ic <= 24'sh3e9;
    wevt(EV_ACT, 4'h0);
    chk("pickup delay", n >= 2 * SC, 32'h1);
    chk("activation data", data, 32'h3e9);
    wevt(EV_RLY_CLOSE, 4'h0);
    chk("relay closed", rly, 32'h1);
    rreg("alarm log", REG_ALOG, 32'h0);
    ic <= 24'sh3e7;
    wevt(EV_DEACT, 4'h0);
    chk("release wait", n >= SC, 32'h1);
    wevt(EV_RLY_OPEN, 4'h0);
    $display("test alarm done");
    @(posedge mclk);
    brk <= 1'b1;
    wreg(REG_CTRL, 32'h1);
    rreg("status", REG_STATUS, 32'h6);
    wreg(REG_RCMD, 32'h1);
    wevt(EV_COMM_CLOSE, ALOG_COMM_CLOSE);
    chk("remote close", rly, 32'h1);
    rreg("remote alarm log", REG_ALOG, ALOG_COMM_CLOSE);
    wreg(REG_RCMD, 32'h2);
    wevt(EV_COMM_OPEN, ALOG_COMM_OPEN);
    @(posedge mclk);
    ic <= 24'sh3e9;
    wevt(EV_ACT, 4'h0);
    repeat (4) @(negedge mclk);
    chk("manual holds relay", rly, 32'h0);
    wreg(REG_CTRL, 32'h0);
    wevt(EV_RLY_CLOSE, 4'h0);
    wreg(REG_RCMD, 32'h2);
    repeat (4) @(negedge mclk);
    chk("auto ignores command", rly, 32'h1);
    @(posedge mclk);
    ic <= 24'sh3e7;
    wevt(EV_DEACT, 4'h0);
    wevt(EV_RLY_OPEN, 4'h0);
    $display("test manual done");
    wreg(8'h64, 32'h12c);
    wreg(8'h60, 32'h1);
    vbc <= 24'sh32;
    wevt(EV_ACT, 4'h2);
    chk("log only data", data, 32'h32);
    repeat (4) @(negedge mclk);
    chk("log only relay", rly, 32'h0);
    @(posedge mclk);
    vbc <= 24'sh2bc;
    wevt(EV_DEACT, 4'h2);
    $display("test log only done");
    end_sim;
  end
endmodule

// File: test/atr_chk.sv
`timescale 1ns/1ps
module atr_chk (
  input wire logic              MCLK,
  input wire logic              RST,
  input wire logic              AVS_READ,
  input wire logic              AVS_WRITE,
  input wire logic              AVS_WAITREQUEST,
  input wire logic              RELAY_CLOSE,
  input wire logic              EVT_VALID,
  input wire atr_pkg::atr_evt_t EVT_KIND,
  input wire logic [3:0]        EVT_FUNC,
  input wire logic [23:0]       EVT_DATA
);
  import atr_pkg::*;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  bus_wait_a: assert property ($rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST)
    else $error("no wait cycle");
  bus_ack_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("wait too long");
  evt_kind_a: assert property (EVT_VALID |-> EVT_KIND != EV_NONE)
    else $error("empty event");
  close_logged_a: assert property ($rose(RELAY_CLOSE) |-> ##[1:8] (EVT_VALID &&
    (EVT_KIND == EV_RLY_CLOSE || EVT_KIND == EV_COMM_CLOSE))) else $error("close not logged");
  open_logged_a: assert property ($fell(RELAY_CLOSE) |-> ##[1:8] (EVT_VALID &&
    (EVT_KIND == EV_RLY_OPEN || EVT_KIND == EV_COMM_OPEN))) else $error("open not logged");
  deact_plain_a: assert property (EVT_VALID && EVT_KIND == EV_DEACT |-> EVT_DATA == 24'h0)
    else $error("data on release");
  alarm_id_a: assert property (EVT_VALID && (EVT_KIND == EV_ACT || EVT_KIND == EV_DEACT)
    |-> EVT_FUNC < 4'h5) else $error("bad function id");
  comm_id_a: assert property (EVT_VALID && EVT_KIND == EV_COMM_CLOSE
    |-> EVT_FUNC == ALOG_COMM_CLOSE) else $error("bad comm id");
endmodule
bind atr_top atr_chk u_chk (.MCLK, .RST, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST, .RELAY_CLOSE,
  .EVT_VALID, .EVT_KIND, .EVT_FUNC, .EVT_DATA);

// File: test/atr_mst.sv
`timescale 1ns/1ps
module atr_mst (
  input  wire logic        clk,
  input  wire logic        wait_req,
  input  wire logic [31:0] rdata,
  output logic      [7:0]  addr,
  output logic             rd,
  output logic             wr,
  output logic      [31:0] wdata
);
  initial begin
    addr = 8'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
  end
  // Request held until waitrequest sampled low at a rising edge; strobes dropped, address and data left inverted
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    rd <= ~w;
    wr <= w;
    wdata <= d;
    do @(posedge clk); while (wait_req !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
endmodule
